/* File: common/sar_pkg.sv */
// constants and types for the serial address recognition control block
package sar_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_POWER_CONTROL_REG = 8'h87;
  localparam logic [IDX_W-1:0] IDX_IE = 8'hA8;
  localparam logic [IDX_W-1:0] IDX_P0_ADDR = 8'hA9;
  localparam logic [IDX_W-1:0] IDX_P1_ADDR = 8'hAA;
  localparam logic [IDX_W-1:0] IDX_IP = 8'hB8;
  localparam logic [IDX_W-1:0] IDX_P0_MASK = 8'hB9;
  localparam logic [IDX_W-1:0] IDX_P1_MASK = 8'hBA;
  localparam logic [IDX_W-1:0] IDX_PORT1_SERIAL_CONTROL = 8'hC0;
  localparam logic [IDX_W-1:0] IDX_PORT1_DATA_BUFFER = 8'hC1;

  // interrupt enable fields
  localparam int IE_GLOBAL = 7;
  localparam int IE_SER1 = 6;
  localparam int IE_SER0 = 4;
  // interrupt priority fields
  localparam int IP_UNIMP = 7;
  localparam int IP_SER1 = 6;
  localparam int IP_SER0 = 4;
  // port 1 serial control fields
  localparam int SC_MODE0_FE = 7;
  localparam int SC_MODE1 = 6;
  localparam int SC_MULTI = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_FLAG = 1;
  localparam int SC_RX_FLAG = 0;
  // power control fields
  localparam int PC_DOUBLE = 7;
  localparam int PC_FE_SEL = 6;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IP_READ_ONES = 8'h80;

  // shift clock dividers in core clocks
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] MODE0_SLOW_DIV = 7'h0C;
  localparam logic [DIV_W-1:0] MODE0_FAST_DIV = 7'h04;
  localparam logic [DIV_W-1:0] MODE2_SLOW_DIV = 7'h40;
  localparam logic [DIV_W-1:0] MODE2_FAST_DIV = 7'h20;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_SYNC8 = 2'h0,
    MODE_ASYNC10 = 2'h1,
    MODE_ASYNC11_FIXED = 2'h2,
    MODE_ASYNC11_VAR = 2'h3
  } sar_mode_t;

  // one received frame as the shift engine reports it
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop_ok;
  } sar_rx_evt_t;

  // interrupt request toward the core's priority logic
  typedef struct packed {
    logic req;
    logic high_prio;
  } sar_irq_t;
endpackage

/* File: rtl/sar_ctrl.sv */
// serial port 1 control and address recognition for both serial ports
// Functional notes
// - port 1 station address register, software writable
// - port 0 mask one compares address bit
// - port 0 mask zero makes bit don't-care
// - port 0 zero mask accepts any address
// - port 1 mask one compares address bit
// - port 1 mask zero makes bit don't-care
// - port 1 zero mask accepts any address
// - control bit 7 is mode or framing flag
// - framing flag set on invalid stop bit
// - mode bits pick one of four frame modes
// - modes 2/3 multiproc: ninth zero blocks receive flag
// - mode 1 multiproc: bad stop blocks flag
// - mode 0 multiproc zero shifts at clock/12
// - port 1 priority bit one means high
// - port 0 priority bit one means high
// - priority bit 7 always reads one
// - port 3 pins carry serial 0 data
// - mode 0 multiproc one shifts at clock/4
// - receive flag set at frame end event
// - transmit flag set by hardware, software clears
// - data reads receive buffer, writes transmit buffer
//
// The AXI4-Lite register port was left to the implementer.
module sar_ctrl
  import sar_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // register bus
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // port 0 shift engine
  input wire logic rx0_evt_valid_in,
  input wire sar_rx_evt_t rx0_evt_in,
  input wire logic rx0_multiproc_in,
  input wire logic rx0_flag_in,
  input wire logic tx0_flag_in,
  output logic rx0_accept_out,
  // port 1 shift engine
  input wire logic rx1_evt_valid_in,
  input wire sar_rx_evt_t rx1_evt_in,
  input wire logic tx1_stop_start_in,
  input wire logic tmr_baud_en_in,
  output logic p1_bit_en_out,
  output sar_mode_t p1_mode_out,
  output logic p1_rx_enable_out,
  output logic p1_tx_ninth_out,
  output logic [7:0] p1_tx_data_out,
  output logic p1_tx_start_out,
  // port 3 serial pins
  input wire logic p3_rxd_pin_in,
  input wire logic ser0_txd_in,
  input wire logic ser0_alt_en_in,
  output logic ser0_rxd_out,
  output logic p3_txd_out,
  output logic p3_txd_oe_out,
  // interrupt requests
  output sar_irq_t ser0_irq_out,
  output sar_irq_t ser1_irq_out
);

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[IDX_W+1:2];
    is_mapped = (addr[ADDR_W-1:IDX_W+2] == '0) && (addr[1:0] == 2'h0) &&
      (idx == IDX_POWER_CONTROL_REG || idx == IDX_IE || idx == IDX_P0_ADDR ||
       idx == IDX_P1_ADDR || idx == IDX_IP || idx == IDX_P0_MASK ||
       idx == IDX_P1_MASK || idx == IDX_PORT1_SERIAL_CONTROL || idx == IDX_PORT1_DATA_BUFFER);
  endfunction

  // masked compare; an all-zero mask matches every address byte
  function automatic logic addr_hit(input logic [7:0] data,
                                    input logic [7:0] own,
                                    input logic [7:0] mask);
    addr_hit = ((data ^ own) & mask) == 8'h00;
  endfunction

  logic [7:0] power_control_reg_ff, ie_ff, ip_ff;
  logic [7:0] p0_addr_ff, p0_mask_ff, p1_addr_ff, p1_mask_ff;
  logic [7:0] scon_ff, rx_buf_ff, tx_buf_ff;
  logic tx_start_ff, rx0_accept_ff;
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [DIV_W-1:0] div_cnt_ff;
  logic bit_en_ff;
  logic fe_ff;

  logic wr_fire;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic wr_byte;
  logic [7:0] rd_val;
  sar_mode_t mode;
  logic multi, fe_sel;
  logic rx1_ok, rx1_set, tx1_set;
  logic [DIV_W-1:0] nxt_div_len;

  // bus write path: address and data taken in either order
  assign s_axi_awready_out = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_out = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_idx = awaddr_ff[IDX_W+1:2];
  assign wr_byte = wr_fire && wstrb0_ff && is_mapped(awaddr_ff);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata_in[7:0];
      wstrb0_ff <= s_axi_wstrb_in[0];
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;

  // plain read/write registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_control_reg_ff <= REG_RESET;
      ie_ff <= REG_RESET;
      ip_ff <= REG_RESET;
      p0_addr_ff <= REG_RESET;
      p0_mask_ff <= REG_RESET;
      p1_addr_ff <= REG_RESET;
      p1_mask_ff <= REG_RESET;
    end else if (wr_byte) begin
      if (wr_idx == IDX_POWER_CONTROL_REG) power_control_reg_ff <= wdata_ff;
      if (wr_idx == IDX_IE) ie_ff <= wdata_ff;
      if (wr_idx == IDX_IP) ip_ff <= wdata_ff;
      if (wr_idx == IDX_P0_ADDR) p0_addr_ff <= wdata_ff;
      if (wr_idx == IDX_P0_MASK) p0_mask_ff <= wdata_ff;
      if (wr_idx == IDX_P1_ADDR) p1_addr_ff <= wdata_ff;
      if (wr_idx == IDX_P1_MASK) p1_mask_ff <= wdata_ff;
    end
  end

  // port 1 mode and gating
  assign fe_sel = power_control_reg_ff[PC_FE_SEL];
  assign multi = scon_ff[SC_MULTI];
  assign mode = sar_mode_t'({scon_ff[SC_MODE0_FE], scon_ff[SC_MODE1]});

  // receive acceptance by mode, multiproc gating and address match
  always_comb begin
    rx1_ok = 1'b1;
    unique case (mode)
      MODE_SYNC8: rx1_ok = 1'b1;
      MODE_ASYNC10: rx1_ok = !multi || rx1_evt_in.stop_ok;
      MODE_ASYNC11_FIXED, MODE_ASYNC11_VAR: begin
        rx1_ok = !multi || (rx1_evt_in.ninth &&
          addr_hit(rx1_evt_in.data, p1_addr_ff, p1_mask_ff));
      end
    endcase
  end

  assign rx1_set = rx1_evt_valid_in && scon_ff[SC_RX_EN] && rx1_ok;
  assign tx1_set = tx1_stop_start_in;

  // port 1 control: hardware set wins over a software clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scon_ff <= REG_RESET;
    end else begin
      if (wr_byte && wr_idx == IDX_PORT1_SERIAL_CONTROL) begin
        scon_ff[SC_MODE1:SC_TX_NINTH] <= wdata_ff[SC_MODE1:SC_TX_NINTH];
        scon_ff[SC_RX_NINTH] <= wdata_ff[SC_RX_NINTH];
        scon_ff[SC_TX_FLAG] <= wdata_ff[SC_TX_FLAG];
        scon_ff[SC_RX_FLAG] <= wdata_ff[SC_RX_FLAG];
        if (!fe_sel) scon_ff[SC_MODE0_FE] <= wdata_ff[SC_MODE0_FE];
      end
      if (rx1_set) begin
        scon_ff[SC_RX_FLAG] <= 1'b1;
        if (mode == MODE_ASYNC10) begin
          scon_ff[SC_RX_NINTH] <= rx1_evt_in.stop_ok;
        end else if (mode != MODE_SYNC8) begin
          scon_ff[SC_RX_NINTH] <= rx1_evt_in.ninth;
        end
      end
      if (tx1_set) begin
        scon_ff[SC_TX_FLAG] <= 1'b1;
      end
    end
  end

  // framing flag is its own bit; power control picks what bit 7 reaches
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fe_ff <= 1'b0;
    end else begin
      if (wr_byte && wr_idx == IDX_PORT1_SERIAL_CONTROL && fe_sel) begin
        fe_ff <= wdata_ff[SC_MODE0_FE];
      end
      if (fe_sel && rx1_evt_valid_in && scon_ff[SC_RX_EN] &&
          mode != MODE_SYNC8 && !rx1_evt_in.stop_ok) begin
        fe_ff <= 1'b1;
      end
    end
  end

  // separate receive and transmit buffers behind one location
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_buf_ff <= REG_RESET;
    end else if (rx1_set) begin
      rx_buf_ff <= rx1_evt_in.data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_buf_ff <= REG_RESET;
      tx_start_ff <= 1'b0;
    end else begin
      tx_start_ff <= wr_byte && wr_idx == IDX_PORT1_DATA_BUFFER;
      if (wr_byte && wr_idx == IDX_PORT1_DATA_BUFFER) begin
        tx_buf_ff <= wdata_ff;
      end
    end
  end

  // port 0 address byte recognition
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx0_accept_ff <= 1'b0;
    end else begin
      rx0_accept_ff <= rx0_evt_valid_in && (!rx0_multiproc_in ||
        !rx0_evt_in.ninth ||
        addr_hit(rx0_evt_in.data, p0_addr_ff, p0_mask_ff));
    end
  end

  // shift clock enable: fixed dividers in modes 0 and 2, timer otherwise
  always_comb begin
    nxt_div_len = MODE0_SLOW_DIV;
    unique case (mode)
      MODE_SYNC8: begin
        nxt_div_len = multi ? MODE0_FAST_DIV : MODE0_SLOW_DIV;
      end
      MODE_ASYNC11_FIXED: begin
        nxt_div_len = power_control_reg_ff[PC_DOUBLE] ? MODE2_FAST_DIV : MODE2_SLOW_DIV;
      end
      MODE_ASYNC10, MODE_ASYNC11_VAR: nxt_div_len = MODE0_SLOW_DIV;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt_ff <= '0;
      bit_en_ff <= 1'b0;
    end else if (mode == MODE_ASYNC10 || mode == MODE_ASYNC11_VAR) begin
      div_cnt_ff <= '0;
      bit_en_ff <= tmr_baud_en_in;
    end else if (div_cnt_ff >= nxt_div_len - 7'h01) begin
      div_cnt_ff <= '0;
      bit_en_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 7'h01;
      bit_en_ff <= 1'b0;
    end
  end

  // read path
  always_comb begin
    rd_idx = s_axi_araddr_in[IDX_W+1:2];
    rd_val = 8'h00;
    unique case (rd_idx)
      IDX_POWER_CONTROL_REG: rd_val = power_control_reg_ff;
      IDX_IE: rd_val = ie_ff;
      IDX_IP: rd_val = ip_ff | IP_READ_ONES;
      IDX_P0_ADDR: rd_val = p0_addr_ff;
      IDX_P0_MASK: rd_val = p0_mask_ff;
      IDX_P1_ADDR: rd_val = p1_addr_ff;
      IDX_P1_MASK: rd_val = p1_mask_ff;
      IDX_PORT1_SERIAL_CONTROL: rd_val = fe_sel ? {fe_ff, scon_ff[SC_MODE1:0]} : scon_ff;
      IDX_PORT1_DATA_BUFFER: rd_val = rx_buf_ff;
      default: rd_val = 8'h00;
    endcase
  end

  assign s_axi_arready_out = !rvalid_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= is_mapped(s_axi_araddr_in) ? {24'h000000, rd_val} : '0;
      rresp_ff <= is_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign s_axi_rresp_out = rresp_ff;

  // outputs toward engines, pins and core
  assign p1_bit_en_out = bit_en_ff;
  assign p1_mode_out = mode;
  assign p1_rx_enable_out = scon_ff[SC_RX_EN];
  assign p1_tx_ninth_out = scon_ff[SC_TX_NINTH];
  assign p1_tx_data_out = tx_buf_ff;
  assign p1_tx_start_out = tx_start_ff;
  assign rx0_accept_out = rx0_accept_ff;
  assign ser0_rxd_out = p3_rxd_pin_in;
  assign p3_txd_out = ser0_txd_in;
  assign p3_txd_oe_out = ser0_alt_en_in;
  assign ser0_irq_out.req = ie_ff[IE_GLOBAL] && ie_ff[IE_SER0] &&
    (rx0_flag_in || tx0_flag_in);
  assign ser0_irq_out.high_prio = ip_ff[IP_SER0];
  assign ser1_irq_out.req = ie_ff[IE_GLOBAL] && ie_ff[IE_SER1] &&
    (scon_ff[SC_RX_FLAG] || scon_ff[SC_TX_FLAG]);
  assign ser1_irq_out.high_prio = ip_ff[IP_SER1];

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  rx_flag_gate_a: assert property (rx1_set |=> scon_ff[SC_RX_FLAG])
    else $error("receive flag not set after accepted frame");
  ninth_block_a: assert property (
    (mode[1] && multi && rx1_evt_valid_in && !rx1_evt_in.ninth &&
     !scon_ff[SC_RX_FLAG] && !(wr_byte && wr_idx == IDX_PORT1_SERIAL_CONTROL))
    |=> !scon_ff[SC_RX_FLAG])
    else $error("receive flag set on data byte in multiproc mode");
  stop_block_a: assert property (
    (mode == MODE_ASYNC10 && multi && rx1_evt_valid_in &&
     !rx1_evt_in.stop_ok && !scon_ff[SC_RX_FLAG] &&
     !(wr_byte && wr_idx == IDX_PORT1_SERIAL_CONTROL)) |=> !scon_ff[SC_RX_FLAG])
    else $error("receive flag set on bad stop in multiproc mode");
  fe_sticky_a: assert property (
    (fe_sel && scon_ff[SC_RX_EN] && mode != MODE_SYNC8 &&
     rx1_evt_valid_in && !rx1_evt_in.stop_ok) |=> fe_ff)
    else $error("framing flag missed an invalid stop bit");
  mode_bit_keep_a: assert property (
    (fe_sel && !(wr_byte && wr_idx == IDX_PORT1_SERIAL_CONTROL)) |=>
    $stable(scon_ff[SC_MODE0_FE]))
    else $error("mode bit changed while bit 7 is the framing flag");
  tx_flag_set_a: assert property (
    tx1_stop_start_in |=> scon_ff[SC_TX_FLAG])
    else $error("transmit flag not set");
  ip_top_one_a: assert property (
    (s_axi_arvalid_in && !rvalid_ff && s_axi_araddr_in == ADDR_W'(
     {IDX_IP, 2'h0})) |=> rdata_ff[IP_UNIMP])
    else $error("priority bit 7 read low");
  irq_enable_a: assert property (
    ser1_irq_out.req |-> (ie_ff[IE_GLOBAL] && ie_ff[IE_SER1]))
    else $error("port 1 interrupt without enables");
  fast_clock_a: assert property (
    (mode == MODE_SYNC8 && multi && bit_en_ff) ##1
    (mode == MODE_SYNC8 && multi) [*3] |=> bit_en_ff)
    else $error("mode 0 fast shift enable not every 4 clocks");
  p0_match_a: assert property (
    (rx0_evt_valid_in && p0_mask_ff == 8'h00) |=> rx0_accept_ff)
    else $error("zero mask did not accept address byte");
  buf_split_a: assert property (
    (wr_byte && wr_idx == IDX_PORT1_DATA_BUFFER && !rx1_set) |=> $stable(rx_buf_ff))
    else $error("transmit write disturbed receive buffer");

endmodule

/* File: verif/sar_far_station.sv */
// far station model: delivers received frames to both shift engines
module sar_far_station
  import sar_pkg::*;
(
  // clock
  input wire logic clk_in,
  // port 0 frame events
  output logic rx0_evt_valid_out,
  output sar_rx_evt_t rx0_evt_out,
  // port 1 frame events
  output logic rx1_evt_valid_out,
  output sar_rx_evt_t rx1_evt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx0_evt_valid_out = 1'b0;
    rx1_evt_valid_out = 1'b0;
    rx0_evt_out = '0;
    rx1_evt_out = '0;
  end
  // one frame for one cycle; afterwards the bus shows the inverse
  task automatic send(input logic port, input logic [7:0] d,
                      input logic ninth, input logic stop_ok);
    sar_rx_evt_t e;
    e = {d, ninth, stop_ok};
    @(posedge clk_in);
    if (port) begin
      rx1_evt_valid_out <= 1'b1;
      rx1_evt_out <= e;
    end else begin
      rx0_evt_valid_out <= 1'b1;
      rx0_evt_out <= e;
    end
    @(posedge clk_in);
    rx0_evt_valid_out <= 1'b0;
    rx1_evt_valid_out <= 1'b0;
    if (port) rx1_evt_out <= ~e;
    else rx0_evt_out <= ~e;
  endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the serial address recognition control block
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb
  import sar_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic rx0v, rx1v, rx0_mp, rx0_flag, rx0_acc, tx1_stop, bit_en;
  logic rx_en, tx_ninth, tx_start, rxd_pin, txd0, alt_en, rxd0;
  logic txd_pin, txd_oe;
  logic tx0_flag, baud;
  sar_rx_evt_t rx0e, rx1e;
  sar_mode_t p1_mode;
  logic [7:0] tx_data;
  sar_irq_t irq0, irq1;
  int num_errors = 0, num_checks = 0;
  int tx_starts = 0;

  always #2 clk = ~clk;

  // transmit start pulses seen, one per data buffer write
  always @(posedge clk) if (tx_start === 1'b1) tx_starts++;

  sar_far_station i_sar_far_station (.clk_in(clk),
    .rx0_evt_valid_out(rx0v), .rx0_evt_out(rx0e),
    .rx1_evt_valid_out(rx1v), .rx1_evt_out(rx1e));

  sar_ctrl i_sar_ctrl (.clk_in(clk), .rst_b_in(rst_b),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .rx0_evt_valid_in(rx0v),
    .rx0_evt_in(rx0e), .rx0_multiproc_in(rx0_mp),
    .rx0_flag_in(rx0_flag), .tx0_flag_in(tx0_flag),
    .rx0_accept_out(rx0_acc), .rx1_evt_valid_in(rx1v),
    .rx1_evt_in(rx1e), .tx1_stop_start_in(tx1_stop),
    .tmr_baud_en_in(baud), .p1_bit_en_out(bit_en),
    .p1_mode_out(p1_mode), .p1_rx_enable_out(rx_en),
    .p1_tx_ninth_out(tx_ninth), .p1_tx_data_out(tx_data),
    .p1_tx_start_out(tx_start), .p3_rxd_pin_in(rxd_pin),
    .ser0_txd_in(txd0), .ser0_alt_en_in(alt_en),
    .ser0_rxd_out(rxd0), .p3_txd_out(txd_pin),
    .p3_txd_oe_out(txd_oe), .ser0_irq_out(irq0),
    .ser1_irq_out(irq1));

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout();
    num_errors++;
    print_verdict();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) timeout();
    `CHK(bresp, er)
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) timeout();
    d = rdata;
    rs = rresp;
    @(posedge clk);
  endtask

  task automatic t_reset();
    rd(IDX_IP, q, r);
    `CHK(q, 32'h00000080)
    rd(8'h10, q, r);
    `CHK(r, RESP_SLVERR)
    wr(8'h10, 8'hFF, RESP_SLVERR);
    wr(IDX_P1_ADDR, 8'hA5);
    rd(IDX_P1_ADDR, q, r);
    `CHK(q, 32'h000000A5)
  endtask

  task automatic t_modes();
    for (logic [2:0] m = 3'h0; m < 3'h4; m++) begin
      wr(IDX_PORT1_SERIAL_CONTROL, {m[1:0], 6'h00});
      `CHK(p1_mode, sar_mode_t'(m[1:0]))
    end
  endtask

  task automatic acc0(input logic [7:0] d, input logic n, input logic e);
    i_sar_far_station.send(1'b0, d, n, 1'b1);
    #1;
    `CHK(rx0_acc, e)
    @(posedge clk);
  endtask

  task automatic t_port0();
    rx0_mp <= 1'b1;
    wr(IDX_P0_ADDR, 8'h5A);
    wr(IDX_P0_MASK, 8'h0F);
    acc0(8'h3A, 1'b1, 1'b1);
    acc0(8'h5B, 1'b1, 1'b0);
    acc0(8'h5B, 1'b0, 1'b1);
    wr(IDX_P0_MASK, 8'h00);
    acc0(8'hFF, 1'b1, 1'b1);
    rx0_flag <= 1'b1;
    wr(IDX_IE, 8'h90);
    `CHK(irq0, 2'h2)
    wr(IDX_IP, 8'h10);
    `CHK(irq0, 2'h3)
    rd(IDX_IP, q, r);
    `CHK(q, 32'h00000090)
    wr(IDX_IE, 8'h10);
    `CHK(irq0, 2'h1)
    rx0_flag <= 1'b0;
    tx0_flag <= 1'b1;
    wr(IDX_IE, 8'h90);
    `CHK(irq0, 2'h3)
    tx0_flag <= 1'b0;
  endtask

  task automatic rx1(input logic [7:0] d, input logic n, input logic e);
    i_sar_far_station.send(1'b1, d, n, 1'b1);
    rd(IDX_PORT1_SERIAL_CONTROL, q, r);
    `CHK(q[SC_RX_FLAG], e)
  endtask

  task automatic t_port1();
    wr(IDX_P1_ADDR, 8'h5A);
    wr(IDX_P1_MASK, 8'hF0);
    wr(IDX_PORT1_SERIAL_CONTROL, 8'hF0);
    rx1(8'h53, 1'b1, 1'b1);
    rd(IDX_PORT1_DATA_BUFFER, q, r);
    `CHK(q, 32'h00000053)
    wr(IDX_IE, 8'hC0);
    `CHK(irq1, 2'h2)
    wr(IDX_IP, 8'h40);
    `CHK(irq1, 2'h3)
    wr(IDX_IE, 8'h40);
    `CHK(irq1, 2'h1)
    wr(IDX_PORT1_SERIAL_CONTROL, 8'hF0);
    rx1(8'h63, 1'b1, 1'b0);
    rx1(8'h53, 1'b0, 1'b0);
    wr(IDX_P1_MASK, 8'h00);
    rx1(8'hC3, 1'b1, 1'b1);
  endtask

  task automatic t_frame();
    wr(IDX_PORT1_SERIAL_CONTROL, 8'h70);
    wr(IDX_POWER_CONTROL_REG, 8'h40);
    `CHK(rx_en, 1'b1)
    baud <= 1'b1;
    @(posedge clk);
    baud <= 1'b0;
    #1;
    `CHK(bit_en, 1'b1)
    @(posedge clk);
    i_sar_far_station.send(1'b1, 8'h11, 1'b0, 1'b0);
    rd(IDX_PORT1_SERIAL_CONTROL, q, r);
    `CHK(q & 32'h81, 32'h00000080)
    i_sar_far_station.send(1'b1, 8'h22, 1'b0, 1'b1);
    rd(IDX_PORT1_SERIAL_CONTROL, q, r);
    `CHK(q & 32'h81, 32'h00000081)
    wr(IDX_PORT1_SERIAL_CONTROL, 8'h70);
    rd(IDX_PORT1_SERIAL_CONTROL, q, r);
    `CHK(q & 32'h81, 32'h00000000)
    `CHK(p1_mode, MODE_ASYNC10)
    wr(IDX_POWER_CONTROL_REG, 8'h00);
  endtask

  task automatic gap(input int e);
    int n, k;
    n = 0;
    k = 0;
    while (k < 2 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
      if (bit_en === 1'b1) begin
        if (k == 1) `CHK(n, e)
        k++;
        n = 0;
      end
    end
    if (k < 2) timeout();
    @(posedge clk);
  endtask

  task automatic t_tx();
    wr(IDX_PORT1_SERIAL_CONTROL, 8'h00);
    wr(IDX_PORT1_DATA_BUFFER, 8'h96);
    `CHK(tx_data, 8'h96)
    gap(12);
    // let the first mode 0 transfer run out before the next one
    repeat (150) @(posedge clk);
    wr(IDX_PORT1_SERIAL_CONTROL, 8'h28);
    `CHK(tx_ninth, 1'b1)
    wr(IDX_PORT1_DATA_BUFFER, 8'h69);
    gap(4);
    tx1_stop <= 1'b1;
    @(posedge clk);
    tx1_stop <= 1'b0;
    rd(IDX_PORT1_SERIAL_CONTROL, q, r);
    `CHK(q[SC_TX_FLAG], 1'b1)
    wr(IDX_PORT1_SERIAL_CONTROL, 8'h20);
    rd(IDX_PORT1_SERIAL_CONTROL, q, r);
    `CHK(q[SC_TX_FLAG], 1'b0)
    wr(IDX_PORT1_SERIAL_CONTROL, 8'h80);
    gap(64);
    wr(IDX_POWER_CONTROL_REG, 8'h80);
    gap(32);
    wr(IDX_POWER_CONTROL_REG, 8'h00);
    `CHK(tx_starts, 2)
  endtask

  task automatic t_pins();
    rxd_pin <= 1'b0;
    alt_en <= 1'b1;
    txd0 <= 1'b0;
    #1;
    `CHK({rxd0, txd_pin, txd_oe}, 3'h1)
    @(posedge clk);
    rxd_pin <= 1'b1;
    txd0 <= 1'b1;
    #1;
    `CHK({rxd0, txd_pin, txd_oe}, 3'h7)
    @(posedge clk);
    alt_en <= 1'b0;
    #1;
    `CHK(txd_oe, 1'b0)
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    {rx0_mp, rx0_flag, tx1_stop, rxd_pin, txd0, alt_en} = 6'h00;
    {tx0_flag, baud} = 2'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_port0();
    t_port1();
    t_frame();
    t_tx();
    t_pins();
    print_verdict();
  end
endmodule
